// ---- verilog/line_regs_defs.vh ----
`ifndef LINE_REGS_DEFS_VH
`define LINE_REGS_DEFS_VH

// =====================================================================
// register offsets
`define ADDR_GCI_CTRL 8'h2A
`define ADDR_THR_VALUE 8'h2B
`define ADDR_THR_CTRL 8'h2C
`define ADDR_HYB_TAP1 8'h2D
`define ADDR_IRQ_ENABLE 8'h30
`define ADDR_IRQ_STATUS 8'h31
`define ADDR_IRQ_MASK 8'h32

// =====================================================================
// field positions
`define GCI_B1_EN_BIT 0
`define GCI_B2_EN_BIT 1
`define GCI_FMT_LSB 2
`define GCI_FMT_MSB 3
`define THR_POL_BIT 0
`define THR_MASK_BIT 1
`define THR_SRC_BIT 2
`define THR_FLAG_BIT 3
`define IRQ_EN_BIT 0
`define EVT_THRESHOLD_BIT 0
`define EVT_FRAME_BIT 1
`define EVT_COUNT 2

// =====================================================================
// format codes
`define FMT_ALAW 2'h0
`define FMT_ULAW 2'h1
`define FMT_LIN8 2'h2
`define FMT_LIN16 2'h3

// =====================================================================
// reset values
`define GCI_CTRL_RST 4'h0
`define THR_VALUE_RST 8'h00
`define THR_CTRL_RST 4'h0
`define HYB_TAP1_RST 8'h00
`define IRQ_ENABLE_RST 1'h0
`define IRQ_MASK_RST 2'h0

`endif

// ---- verilog/threshold_cmp.v ----
`timescale 1ns/100ps
`include "line_regs_defs.vh"

module threshold_cmp (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // measurements
  input wire meas_update,
  input wire [7:0] line_current_meas,
  input wire [7:0] line_voltage_meas,
  // configuration
  input wire [7:0] line_threshold,
  input wire threshold_source_sel,
  input wire threshold_polarity,
  // one-cycle pulse when the condition first holds
  output reg crossed_pulse
);

  reg cond_prev_ff;
  wire [7:0] sel_meas;
  wire [7:0] abs_meas;
  wire cond_now;

  assign sel_meas = threshold_source_sel ? line_voltage_meas : line_current_meas;
  // -128 becomes 8'h80, which is still 128 read as unsigned
  assign abs_meas = sel_meas[7] ? (8'h00 - sel_meas) : sel_meas;
  assign cond_now = threshold_polarity ? (abs_meas > line_threshold) :
                    (abs_meas < line_threshold);

  // =====================================================================
  // edge on the condition, evaluated only at measurement updates
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cond_prev_ff <= 1'b0;
      crossed_pulse <= 1'b0;
    end else begin
      crossed_pulse <= 1'b0;
      if (meas_update) begin
        cond_prev_ff <= cond_now;
        crossed_pulse <= cond_now & ~cond_prev_ff;
      end
    end
  end

endmodule // threshold_cmp

// ---- verilog/hybrid_tap.v ----
`timescale 1ns/100ps

module hybrid_tap #(
  parameter COEF_W = 8,
  parameter DATA_W = 16
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // sample stream
  input wire sample_stb,
  input wire [DATA_W-1:0] sample,
  input wire [COEF_W-1:0] coef,
  // weighted tap contribution
  output reg [DATA_W-1:0] tap_out
);

  wire signed [DATA_W+COEF_W-1:0] product;

  // coefficient is Q1.7, so the product is rescaled by 2^(COEF_W-1)
  assign product = $signed(sample) * $signed(coef);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_out <= {DATA_W{1'b0}};
    end else if (sample_stb) begin
      tap_out <= product[DATA_W+COEF_W-2:COEF_W-1];
    end
  end

endmodule // hybrid_tap

// ---- verilog/gci_line_ctrl.v ----
`timescale 1ns/100ps
`include "line_regs_defs.vh"

module gci_line_ctrl (
  // clock and reset
  input wire CLK,
  input wire ARST_N,
  // register port
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR_STB,
  input wire RD_STB,
  output reg [7:0] RDATA,
  // line measurements
  input wire MEAS_UPDATE,
  input wire [7:0] LINE_CURRENT_MEAS,
  input wire [7:0] LINE_VOLTAGE_MEAS,
  // highway frame
  input wire FRAME_STB,
  input wire [15:0] TX_SAMPLE,
  input wire [7:0] B1_RX,
  input wire [7:0] B2_RX,
  output reg [7:0] B1_TX,
  output reg B1_TX_VALID,
  output reg [7:0] B2_TX,
  output reg B2_TX_VALID,
  output reg [15:0] RX_SAMPLE,
  output reg RX_SAMPLE_VALID,
  // hybrid tap one contribution
  output wire [15:0] HYB_ECHO_EST,
  // interrupt
  output reg IRQ_OUT
);

  // =====================================================================
  // register state
  reg [1:0] voice_format_sel_ff;
  reg chan_two_enable_ff;
  reg chan_one_enable_ff;
  reg [7:0] line_threshold_ff;
  reg threshold_crossed_flag_ff;
  reg threshold_source_sel_ff;
  reg threshold_irq_mask_ff;
  reg threshold_polarity_ff;
  reg [7:0] hybrid_tap_one_ff;
  reg global_irq_enable_ff;
  reg [`EVT_COUNT-1:0] irq_status_ff;
  reg [`EVT_COUNT-1:0] irq_mask_ff;

  reg [7:0] nxt_rdata;
  reg [7:0] nxt_b1_tx;
  reg [7:0] nxt_b2_tx;
  reg nxt_b1_valid;
  reg nxt_b2_valid;
  reg [15:0] nxt_rx_sample;
  reg nxt_rx_valid;
  wire nxt_irq;
  wire crossed_pulse;
  wire [`EVT_COUNT-1:0] evt_set;
  wire any_chan;

  // =====================================================================
  // companding helpers
  function [7:0] ulaw_enc;
    input [15:0] s;
    reg sgn;
    reg [13:0] m;
    reg [14:0] mag;
    reg [14:0] tmp;
    reg [2:0] seg;
    integer i;
    begin
      sgn = s[15];
      m = sgn ? ~s[15:2] : s[15:2];
      mag = (m > 14'h1FDE) ? 15'h1FFF : ({1'b0, m} + 15'h0021);
      seg = 3'h0;
      for (i = 0; i < 8; i = i + 1) begin
        if (mag[i+5]) begin
          seg = i[2:0];
        end
      end
      tmp = mag >> ({1'b0, seg} + 4'h1);
      ulaw_enc = ~{sgn, seg, tmp[3:0]};
    end
  endfunction

  function [7:0] alaw_enc;
    input [15:0] s;
    reg sgn;
    reg [11:0] m;
    reg [11:0] tmp;
    reg [2:0] seg;
    integer i;
    begin
      sgn = s[15];
      // ones complement keeps the magnitude in 12 bits without overflow
      m = sgn ? ~s[14:3] : s[14:3];
      seg = 3'h0;
      for (i = 0; i < 7; i = i + 1) begin
        if (m[i+5]) begin
          seg = i[2:0] + 3'h1;
        end
      end
      tmp = (seg == 3'h0) ? (m >> 1) : (m >> seg);
      alaw_enc = {1'b0, seg, tmp[3:0]} ^ (sgn ? 8'h55 : 8'hD5);
    end
  endfunction

  function [15:0] ulaw_dec;
    input [7:0] c;
    reg [7:0] u;
    reg [15:0] t;
    begin
      u = ~c;
      t = ({9'h000, u[3:0], 3'h0} + 16'h0084) << u[6:4];
      ulaw_dec = u[7] ? (16'h0084 - t) : (t - 16'h0084);
    end
  endfunction

  function [15:0] alaw_dec;
    input [7:0] c;
    reg [7:0] a;
    reg [15:0] t;
    begin
      a = c ^ 8'h55;
      t = {8'h00, a[3:0], 4'h0};
      if (a[6:4] == 3'h0) begin
        t = t + 16'h0008;
      end else begin
        t = t + 16'h0108;
        t = t << (a[6:4] - 3'h1);
      end
      alaw_dec = a[7] ? t : (16'h0000 - t);
    end
  endfunction

  // =====================================================================
  // submodules
  threshold_cmp u_cmp (
    .clk(CLK),
    .arst_n(ARST_N),
    .meas_update(MEAS_UPDATE),
    .line_current_meas(LINE_CURRENT_MEAS),
    .line_voltage_meas(LINE_VOLTAGE_MEAS),
    .line_threshold(line_threshold_ff),
    .threshold_source_sel(threshold_source_sel_ff),
    .threshold_polarity(threshold_polarity_ff),
    .crossed_pulse(crossed_pulse)
  );

  hybrid_tap #(
    .COEF_W(8),
    .DATA_W(16)
  ) u_tap1 (
    .clk(CLK),
    .arst_n(ARST_N),
    .sample_stb(FRAME_STB),
    .sample(TX_SAMPLE),
    .coef(hybrid_tap_one_ff),
    .tap_out(HYB_ECHO_EST)
  );

  // =====================================================================
  // register writes and sticky flags
  assign any_chan = chan_one_enable_ff | chan_two_enable_ff;
  assign evt_set = {FRAME_STB & any_chan, crossed_pulse};

  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {voice_format_sel_ff, chan_two_enable_ff, chan_one_enable_ff} <= `GCI_CTRL_RST;
      line_threshold_ff <= `THR_VALUE_RST;
      {threshold_crossed_flag_ff, threshold_source_sel_ff, threshold_irq_mask_ff,
       threshold_polarity_ff} <= `THR_CTRL_RST;
      hybrid_tap_one_ff <= `HYB_TAP1_RST;
      global_irq_enable_ff <= `IRQ_ENABLE_RST;
      irq_mask_ff <= `IRQ_MASK_RST;
      irq_status_ff <= {`EVT_COUNT{1'b0}};
    end else begin
      if (WR_STB) begin
        case (ADDR)
          `ADDR_GCI_CTRL: begin
            // upper nibble is dropped on write
            voice_format_sel_ff <= WDATA[`GCI_FMT_MSB:`GCI_FMT_LSB];
            chan_two_enable_ff <= WDATA[`GCI_B2_EN_BIT];
            chan_one_enable_ff <= WDATA[`GCI_B1_EN_BIT];
          end
          `ADDR_THR_VALUE: begin
            line_threshold_ff <= WDATA;
          end
          `ADDR_THR_CTRL: begin
            threshold_source_sel_ff <= WDATA[`THR_SRC_BIT];
            threshold_irq_mask_ff <= WDATA[`THR_MASK_BIT];
            threshold_polarity_ff <= WDATA[`THR_POL_BIT];
          end
          `ADDR_HYB_TAP1: begin
            hybrid_tap_one_ff <= WDATA;
          end
          `ADDR_IRQ_ENABLE: begin
            global_irq_enable_ff <= WDATA[`IRQ_EN_BIT];
          end
          `ADDR_IRQ_MASK: begin
            irq_mask_ff <= WDATA[`EVT_COUNT-1:0];
          end
          default: begin
          end
        endcase
      end
      // writing 1 never sets the flag; a new crossing beats a clear
      if (crossed_pulse) begin
        threshold_crossed_flag_ff <= 1'b1;
      end else if (WR_STB && (ADDR == `ADDR_THR_CTRL) && !WDATA[`THR_FLAG_BIT]) begin
        threshold_crossed_flag_ff <= 1'b0;
      end
      // read of the status register clears it, new events win
      if (RD_STB && (ADDR == `ADDR_IRQ_STATUS)) begin
        irq_status_ff <= evt_set;
      end else begin
        irq_status_ff <= irq_status_ff | evt_set;
      end
    end
  end

  // =====================================================================
  // read data, one cycle after the strobe
  always @* begin
    nxt_rdata = 8'h00;
    case (ADDR)
      `ADDR_GCI_CTRL: begin
        nxt_rdata = {4'h0, voice_format_sel_ff, chan_two_enable_ff,
                     chan_one_enable_ff};
      end
      `ADDR_THR_VALUE: begin
        nxt_rdata = line_threshold_ff;
      end
      `ADDR_THR_CTRL: begin
        nxt_rdata = {4'h0, threshold_crossed_flag_ff, threshold_source_sel_ff,
                     threshold_irq_mask_ff, threshold_polarity_ff};
      end
      `ADDR_HYB_TAP1: begin
        nxt_rdata = hybrid_tap_one_ff;
      end
      `ADDR_IRQ_ENABLE: begin
        nxt_rdata = {7'h00, global_irq_enable_ff};
      end
      `ADDR_IRQ_STATUS: begin
        nxt_rdata = {6'h00, irq_status_ff};
      end
      `ADDR_IRQ_MASK: begin
        nxt_rdata = {6'h00, irq_mask_ff};
      end
      default: begin
        nxt_rdata = 8'h00;
      end
    endcase
  end

  // =====================================================================
  // interrupt output
  // the threshold flag has its own mask and does not go through the status mask
  assign nxt_irq = global_irq_enable_ff &
                   ((threshold_crossed_flag_ff & threshold_irq_mask_ff) |
                    (|(irq_status_ff & irq_mask_ff)));

  // =====================================================================
  // highway slot mapping
  always @* begin
    nxt_b1_tx = 8'h00;
    nxt_b2_tx = 8'h00;
    nxt_rx_sample = 16'h0000;
    nxt_b1_valid = FRAME_STB & chan_one_enable_ff;
    nxt_b2_valid = FRAME_STB & chan_two_enable_ff;
    nxt_rx_valid = FRAME_STB & any_chan;
    case (voice_format_sel_ff)
      `FMT_ALAW: begin
        nxt_b1_tx = alaw_enc(TX_SAMPLE);
        nxt_b2_tx = nxt_b1_tx;
        // B1 is preferred for receive when both slots are on
        nxt_rx_sample = alaw_dec(chan_one_enable_ff ? B1_RX : B2_RX);
      end
      `FMT_ULAW: begin
        nxt_b1_tx = ulaw_enc(TX_SAMPLE);
        nxt_b2_tx = nxt_b1_tx;
        nxt_rx_sample = ulaw_dec(chan_one_enable_ff ? B1_RX : B2_RX);
      end
      `FMT_LIN8: begin
        // lower byte is lost in both directions
        nxt_b1_tx = TX_SAMPLE[15:8];
        nxt_b2_tx = TX_SAMPLE[15:8];
        nxt_rx_sample = {chan_one_enable_ff ? B1_RX : B2_RX, 8'h00};
      end
      `FMT_LIN16: begin
        nxt_b1_tx = TX_SAMPLE[15:8];
        nxt_b2_tx = TX_SAMPLE[7:0];
        if (chan_one_enable_ff && chan_two_enable_ff) begin
          nxt_rx_sample = {B1_RX, B2_RX};
        end else if (chan_one_enable_ff) begin
          nxt_rx_sample = {B1_RX, 8'h00};
        end else begin
          nxt_rx_sample = {8'h00, B2_RX};
        end
      end
      default: begin
        nxt_rx_sample = 16'h0000;
      end
    endcase
  end

  // =====================================================================
  // output flip-flops
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      RDATA <= 8'h00;
      IRQ_OUT <= 1'b0;
      B1_TX <= 8'h00;
      B2_TX <= 8'h00;
      B1_TX_VALID <= 1'b0;
      B2_TX_VALID <= 1'b0;
      RX_SAMPLE <= 16'h0000;
      RX_SAMPLE_VALID <= 1'b0;
    end else begin
      RDATA <= RD_STB ? nxt_rdata : 8'h00;
      IRQ_OUT <= nxt_irq;
      B1_TX_VALID <= nxt_b1_valid;
      B2_TX_VALID <= nxt_b2_valid;
      RX_SAMPLE_VALID <= nxt_rx_valid;
      // data stay put between frames, so a disabled slot keeps its old byte
      if (nxt_b1_valid) begin
        B1_TX <= nxt_b1_tx;
      end
      if (nxt_b2_valid) begin
        B2_TX <= nxt_b2_tx;
      end
      if (nxt_rx_valid) begin
        RX_SAMPLE <= nxt_rx_sample;
      end
    end
  end

endmodule // gci_line_ctrl

// ---- dv/host_model.sv ----
`timescale 1ns/100ps
// ==========================================
// control-port host: strobes last one cycle
module host_model (
  // clock
  input wire clk,
  // register port
  output reg [7:0] addr,
  output reg [7:0] wdata,
  output reg wr_stb,
  output reg rd_stb,
  input wire [7:0] rdata
);
  initial begin
    addr = 8'h00;
    wdata = 8'h00;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
  end
  // address and data are scrambled once released, so no stale value helps
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge clk);
      wr_stb <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge clk);
      rd_stb <= 1'b0;
      addr <= ~a;
      #1;
      d = rdata;
    end
  endtask
endmodule // host_model

// ---- dv/gci_line_ctrl_monitor.sv ----
`timescale 1ns/100ps
// ==========================================
// port checker
module gci_line_ctrl_chk (
  // clock and reset
  input wire CLK,
  input wire ARST_N,
  // register port
  input wire [7:0] ADDR,
  input wire [7:0] WDATA,
  input wire WR_STB,
  input wire RD_STB,
  input wire [7:0] RDATA,
  // measurements
  input wire MEAS_UPDATE,
  input wire [7:0] LINE_CURRENT_MEAS,
  input wire [7:0] LINE_VOLTAGE_MEAS,
  // highway and interrupt
  input wire FRAME_STB,
  input wire [15:0] TX_SAMPLE,
  input wire [7:0] B1_TX,
  input wire B1_TX_VALID,
  input wire [7:0] B2_TX,
  input wire B2_TX_VALID,
  input wire [15:0] HYB_ECHO_EST,
  input wire IRQ_OUT
);
  reg [3:0] gci_ff;
  reg [2:0] tc_ff;
  reg [7:0] thr_ff;
  reg [7:0] hyb_ff;
  reg [1:0] m32_ff;
  reg en_ff;
  reg prev_ff;
  wire [7:0] meas = tc_ff[2] ? LINE_VOLTAGE_MEAS : LINE_CURRENT_MEAS;
  wire [8:0] mag = meas[7] ? 9'h100 - {1'b0, meas} : {1'b0, meas};
  wire cond = tc_ff[0] ? (mag > {1'b0, thr_ff}) : (mag < {1'b0, thr_ff});
  wire cfg_wr = WR_STB && (ADDR == 8'h2C || ADDR == 8'h30);
  // shadow of the control registers, taken from the port traffic
  always @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      {gci_ff, tc_ff, thr_ff, hyb_ff, m32_ff, en_ff, prev_ff} <= 27'h0;
    end else begin
      if (WR_STB && ADDR == 8'h2A) gci_ff <= WDATA[3:0];
      if (WR_STB && ADDR == 8'h2B) thr_ff <= WDATA;
      if (WR_STB && ADDR == 8'h2C) tc_ff <= WDATA[2:0];
      if (WR_STB && ADDR == 8'h2D) hyb_ff <= WDATA;
      if (WR_STB && ADDR == 8'h30) en_ff <= WDATA[0];
      if (WR_STB && ADDR == 8'h32) m32_ff <= WDATA[1:0];
      if (MEAS_UPDATE) prev_ff <= cond;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  sequence s_armed;
    MEAS_UPDATE && cond && !prev_ff && en_ff && tc_ff[1] && !cfg_wr;
  endsequence
  sequence s_quiet;
    !cfg_wr [*2];
  endsequence
  a_rsvd_zero: assert property (
    $past(RD_STB) && ($past(ADDR) == 8'h2A || $past(ADDR) == 8'h2C) |-> RDATA[7:4] == 4'h0)
    else $error("reserved bits read nonzero");
  a_b1_gate: assert property (
    B1_TX_VALID == ($past(FRAME_STB) && $past(gci_ff[0]))) else $error("b1 gating wrong");
  a_b2_gate: assert property (
    B2_TX_VALID == ($past(FRAME_STB) && $past(gci_ff[1]))) else $error("b2 gating wrong");
  a_lin_b1: assert property (
    FRAME_STB && gci_ff[0] && gci_ff[3] |=> B1_TX == $past(TX_SAMPLE[15:8]))
    else $error("b1 linear byte wrong");
  a_lin_b2: assert property (
    FRAME_STB && gci_ff[1] && gci_ff[3:2] == 2'h3 |=> B2_TX == $past(TX_SAMPLE[7:0]))
    else $error("b2 linear byte wrong");
  a_irq_enable: assert property (
    IRQ_OUT |-> $past(en_ff)) else $error("irq without global enable");
  a_mask_blocks: assert property (
    IRQ_OUT |-> $past(tc_ff[1]) || $past(m32_ff) != 2'h0) else $error("irq while masked");
  a_cross_irq: assert property (
    s_armed ##1 s_quiet |=> IRQ_OUT) else $error("crossing gave no irq");
  a_zero_tap: assert property (
    FRAME_STB && hyb_ff == 8'h00 |=> HYB_ECHO_EST == 16'h0000) else $error("zero tap nonzero");
endmodule // gci_line_ctrl_chk

bind gci_line_ctrl gci_line_ctrl_chk u_chk (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR),
  .WDATA(WDATA), .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA),
  .MEAS_UPDATE(MEAS_UPDATE), .LINE_CURRENT_MEAS(LINE_CURRENT_MEAS),
  .LINE_VOLTAGE_MEAS(LINE_VOLTAGE_MEAS), .FRAME_STB(FRAME_STB), .TX_SAMPLE(TX_SAMPLE),
  .B1_TX(B1_TX), .B1_TX_VALID(B1_TX_VALID), .B2_TX(B2_TX), .B2_TX_VALID(B2_TX_VALID),
  .HYB_ECHO_EST(HYB_ECHO_EST), .IRQ_OUT(IRQ_OUT));

// ---- dv/tb_gci_format_threshold_irq_regs.sv ----
`timescale 1ns/100ps
// ==========================================
// testbench
module tb_gci_format_threshold_irq_regs;
  reg CLK;
  reg ARST_N;
  wire [7:0] ADDR;
  wire [7:0] WDATA;
  wire WR_STB;
  wire RD_STB;
  wire [7:0] RDATA;
  reg MEAS_UPDATE;
  reg [7:0] LINE_CURRENT_MEAS;
  reg [7:0] LINE_VOLTAGE_MEAS;
  reg FRAME_STB;
  reg [15:0] TX_SAMPLE;
  reg [7:0] B1_RX;
  reg [7:0] B2_RX;
  wire [7:0] B1_TX;
  wire B1_TX_VALID;
  wire [7:0] B2_TX;
  wire B2_TX_VALID;
  wire [15:0] RX_SAMPLE;
  wire RX_SAMPLE_VALID;
  wire [15:0] HYB_ECHO_EST;
  wire IRQ_OUT;
  integer n_fail;
  integer num_checks;
  integer i;
  reg [7:0] rv;
  gci_line_ctrl u_dut (.CLK(CLK), .ARST_N(ARST_N), .ADDR(ADDR), .WDATA(WDATA),
    .WR_STB(WR_STB), .RD_STB(RD_STB), .RDATA(RDATA), .MEAS_UPDATE(MEAS_UPDATE),
    .LINE_CURRENT_MEAS(LINE_CURRENT_MEAS), .LINE_VOLTAGE_MEAS(LINE_VOLTAGE_MEAS),
    .FRAME_STB(FRAME_STB), .TX_SAMPLE(TX_SAMPLE), .B1_RX(B1_RX), .B2_RX(B2_RX),
    .B1_TX(B1_TX), .B1_TX_VALID(B1_TX_VALID), .B2_TX(B2_TX), .B2_TX_VALID(B2_TX_VALID),
    .RX_SAMPLE(RX_SAMPLE), .RX_SAMPLE_VALID(RX_SAMPLE_VALID),
    .HYB_ECHO_EST(HYB_ECHO_EST), .IRQ_OUT(IRQ_OUT));
  host_model u_host (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr_stb(WR_STB),
    .rd_stb(RD_STB), .rdata(RDATA));
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end
  task close_out;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [15:0] got, input [15:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [7:0] exp);
    begin
      u_host.rd(a, rv);
      chk({8'h00, rv}, {8'h00, exp});
    end
  endtask
  // one frame under a given channel setup; data checked only on enabled slots
  task frame(input [3:0] c, input [15:0] tx, input [7:0] e1, input [7:0] e2,
    input [15:0] erx);
    begin
      u_host.wr(8'h2A, {4'h0, c});
      @(posedge CLK);
      FRAME_STB <= 1'b1;
      TX_SAMPLE <= tx;
      @(posedge CLK);
      FRAME_STB <= 1'b0;
      #1;
      chk({15'h0000, B1_TX_VALID}, {15'h0000, c[0]});
      chk({15'h0000, B2_TX_VALID}, {15'h0000, c[1]});
      chk({15'h0000, RX_SAMPLE_VALID}, {15'h0000, |c[1:0]});
      if (c[0]) chk({8'h00, B1_TX}, {8'h00, e1});
      if (c[1]) chk({8'h00, B2_TX}, {8'h00, e2});
      if (c[1:0] != 2'h0) chk(RX_SAMPLE, erx);
    end
  endtask
  task meas(input [7:0] cur, input [7:0] vol);
    begin
      @(posedge CLK);
      MEAS_UPDATE <= 1'b1;
      LINE_CURRENT_MEAS <= cur;
      LINE_VOLTAGE_MEAS <= vol;
      @(posedge CLK);
      MEAS_UPDATE <= 1'b0;
      repeat (3) @(posedge CLK);
      #1;
    end
  endtask
  initial begin
    #100000;
    n_fail = n_fail + 1;
    close_out;
  end
  // ==========================================
  // test sequence
  initial begin
    n_fail = 0;
    num_checks = 0;
    ARST_N = 1'b0;
    MEAS_UPDATE = 1'b0;
    LINE_CURRENT_MEAS = 8'h00;
    LINE_VOLTAGE_MEAS = 8'h00;
    FRAME_STB = 1'b0;
    TX_SAMPLE = 16'h0000;
    B1_RX = 8'hAB;
    B2_RX = 8'hCD;
    repeat (10) @(posedge CLK);
    ARST_N <= 1'b1;
    for (i = 0; i < 4; i = i + 1) rchk(8'h2A + i[7:0], 8'h00);
    u_host.wr(8'h2A, 8'hFF);
    rchk(8'h2A, 8'h0F);
    u_host.wr(8'h2C, 8'hFF);
    rchk(8'h2C, 8'h07);
    u_host.wr(8'h2B, 8'hA5);
    rchk(8'h2B, 8'hA5);
    u_host.wr(8'h40, 8'h5A);
    rchk(8'h40, 8'h00);
    frame(4'hF, 16'h1234, 8'h12, 8'h34, 16'hABCD);
    frame(4'hD, 16'h1234, 8'h12, 8'h00, 16'hAB00);
    frame(4'hE, 16'h1234, 8'h00, 8'h34, 16'h00CD);
    frame(4'hB, 16'h1234, 8'h12, 8'h12, 16'hAB00);
    frame(4'hC, 16'h1234, 8'h00, 8'h00, 16'h0000);
    frame(4'h3, 16'h0000, 8'hD5, 8'hD5, 16'h7A00);
    frame(4'h7, 16'h0000, 8'hFF, 8'hFF, 16'h13FC);
    frame(4'h1, 16'h1234, 8'h87, 8'h00, 16'h7A00);
    frame(4'h6, 16'h1234, 8'h00, 8'hAD, 16'h041C);
    rchk(8'h31, 8'h02);
    rchk(8'h31, 8'h00);
    u_host.wr(8'h30, 8'h01);
    u_host.wr(8'h32, 8'h02);
    frame(4'h9, 16'h1234, 8'h12, 8'h00, 16'hAB00);
    repeat (2) @(posedge CLK);
    #1;
    chk({15'h0000, IRQ_OUT}, 16'h0001);
    rchk(8'h31, 8'h02);
    repeat (2) @(posedge CLK);
    #1;
    chk({15'h0000, IRQ_OUT}, 16'h0000);
    u_host.wr(8'h32, 8'h00);
    u_host.wr(8'h2D, 8'h40);
    rchk(8'h2D, 8'h40);
    frame(4'hF, 16'h1000, 8'h10, 8'h00, 16'hABCD);
    chk(HYB_ECHO_EST, 16'h0800);
    u_host.wr(8'h2D, 8'h00);
    frame(4'hF, 16'h7FFF, 8'h7F, 8'hFF, 16'hABCD);
    chk(HYB_ECHO_EST, 16'h0000);
    u_host.wr(8'h2B, 8'h0A);
    u_host.wr(8'h2C, 8'h02);
    meas(8'hFB, 8'h00);
    chk({15'h0000, IRQ_OUT}, 16'h0001);
    u_host.wr(8'h2C, 8'h0A);
    rchk(8'h2C, 8'h0A);
    u_host.wr(8'h30, 8'h00);
    rchk(8'h30, 8'h00);
    chk({15'h0000, IRQ_OUT}, 16'h0000);
    u_host.wr(8'h30, 8'h01);
    u_host.wr(8'h2C, 8'h02);
    rchk(8'h2C, 8'h02);
    chk({15'h0000, IRQ_OUT}, 16'h0000);
    rchk(8'h31, 8'h03);
    meas(8'hFB, 8'h00);
    rchk(8'h2C, 8'h02);
    u_host.wr(8'h2C, 8'h04);
    meas(8'hFB, 8'h14);
    meas(8'hFB, 8'hF6);
    rchk(8'h2C, 8'h04);
    meas(8'hFB, 8'hF7);
    rchk(8'h2C, 8'h0C);
    chk({15'h0000, IRQ_OUT}, 16'h0000);
    u_host.wr(8'h2C, 8'h07);
    meas(8'h00, 8'h05);
    rchk(8'h2C, 8'h07);
    meas(8'h00, 8'h80);
    rchk(8'h2C, 8'h0F);
    chk({15'h0000, IRQ_OUT}, 16'h0001);
    close_out;
  end
endmodule // tb_gci_format_threshold_irq_regs
